// *** verilog/dcbs_decoder.sv ***
// Command decoder and per-bank state tracker for a DDR2 device
module dcbs_decoder #(
    parameter int BANK_BITS = 3,
    parameter bit DENSITY_1G = 1'b1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire dcbs_pkg::dcbs_pins_t pins,
    input wire logic odt,
    output logic odt_active_ff,
    output dcbs_pkg::dcbs_dec_t cmd_ff,
    output logic cmd_accepted_ff,
    output logic cmd_rejected_ff,
    output logic mode_load_ff,
    output logic [2:0] mode_sel_ff,
    output logic [13:0] mode_op_ff,
    output logic act_ff,
    output logic rd_ff,
    output logic wr_ff,
    output logic [2:0] access_bank_ff,
    output logic [13:0] access_addr_ff,
    output logic refresh_ff,
    output dcbs_pkg::dcbs_dev_t dev_state_ff,
    output logic [6:0] bank_state_ff [8]
);
    import dcbs_pkg::*;

    localparam int NB = 1 << BANK_BITS;

    dcbs_pins_t pin_s1_ff;
    dcbs_pins_t pin_s2_ff;
    logic cke_prev_ff;
    logic sref_wake_ff;
    logic sref_wake_s1_ff;
    logic sref_wake_s2_ff;
    logic [TMR_W-1:0] dev_tmr_ff;
    dcbs_bank_t bank_ff [NB];
    logic [TMR_W-1:0] bank_tmr_ff [NB];
    logic [NB-1:0] bank_ap_ff;
    dcbs_dec_t dec;
    logic [2:0] bank_sel;
    logic all_idle;
    logic xsnr_done;
    logic wake_arm_n;

    // Two-stage sampling of the command pins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= pins;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Clock enable of the previous edge, for the two-cycle qualification
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cke_prev_ff <= 1'b0;
        end else begin
            cke_prev_ff <= pin_s2_ff.cke;
        end
    end

    // Wake flag held clear outside self refresh, so a power-down exit edge cannot linger
    assign wake_arm_n = reset_n && (dev_state_ff == DEV_SELF_REF);

    // Self refresh wake: set by the raw clock-enable edge, not the sampled one
    always_ff @(posedge pins.cke or negedge wake_arm_n) begin
        if (!wake_arm_n) begin
            sref_wake_ff <= 1'b0;
        end else begin
            sref_wake_ff <= 1'b1;
        end
    end

    // Wake flag crosses into the clock domain before use
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sref_wake_s1_ff <= 1'b0;
            sref_wake_s2_ff <= 1'b0;
        end else begin
            sref_wake_s1_ff <= sref_wake_ff;
            sref_wake_s2_ff <= sref_wake_s1_ff;
        end
    end

    // Bank select; top bit masked on small densities
    assign bank_sel = DENSITY_1G ? pin_s2_ff.bank : {1'b0, pin_s2_ff.bank[1:0]};

    // Pure level decode; termination input deliberately plays no part
    always_comb begin
        dec = '{cmd: CMD_NONE, bank: bank_sel, addr: pin_s2_ff.addr, auto_pre: pin_s2_ff.addr[AUTO_PRE_BIT]};
        if (cke_prev_ff && pin_s2_ff.cke) begin
            if (!pin_s2_ff.cs_n) begin
                case ({pin_s2_ff.ras_n, pin_s2_ff.cas_n, pin_s2_ff.we_n})
                    3'b000: dec.cmd = CMD_MODE;
                    3'b001: dec.cmd = CMD_REF;
                    3'b010: dec.cmd = pin_s2_ff.addr[AUTO_PRE_BIT] ? CMD_PRE_ALL : CMD_PRE;
                    3'b011: dec.cmd = CMD_ACT;
                    3'b100: dec.cmd = CMD_WR;
                    3'b101: dec.cmd = CMD_RD;
                    3'b111: dec.cmd = CMD_NONE;
                    default: dec.cmd = CMD_ILLEGAL;
                endcase
            end
        end else if (cke_prev_ff && !pin_s2_ff.cke) begin
            if (!pin_s2_ff.cs_n && pin_s2_ff.ras_n == 1'b0 && !pin_s2_ff.cas_n && pin_s2_ff.we_n) begin
                dec.cmd = CMD_SREF_IN;
            end else if (pin_s2_ff.cs_n || (pin_s2_ff.ras_n && pin_s2_ff.cas_n && pin_s2_ff.we_n)) begin
                dec.cmd = CMD_PD_IN;
            end else begin
                dec.cmd = CMD_ILLEGAL;
            end
        end else if (!cke_prev_ff && pin_s2_ff.cke) begin
            if (pin_s2_ff.cs_n || (pin_s2_ff.ras_n && pin_s2_ff.cas_n && pin_s2_ff.we_n)) begin
                dec.cmd = (dev_state_ff == DEV_SELF_REF) ? CMD_SREF_OUT : CMD_PD_OUT;
            end else begin
                dec.cmd = CMD_ILLEGAL;
            end
        end
    end

    // All banks idle and no burst running
    always_comb begin
        all_idle = 1'b1;
        for (int i = 0; i < NB; i++) begin
            if (bank_ff[i] != BK_IDLE) begin
                all_idle = 1'b0;
            end
        end
    end

    assign xsnr_done = (dev_state_ff != DEV_SREF_EXIT);

    // Device-level state: power-down, self refresh and its exit delay
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dev_state_ff <= DEV_NORMAL;
            dev_tmr_ff <= '0;
        end else begin
            case (dev_state_ff)
                DEV_NORMAL: begin
                    if (dec.cmd == CMD_PD_IN) begin
                        dev_state_ff <= DEV_POWER_DOWN;
                    end else if (dec.cmd == CMD_SREF_IN) begin
                        dev_state_ff <= DEV_SELF_REF;
                    end
                end
                DEV_POWER_DOWN: begin
                    if (dec.cmd == CMD_PD_OUT) begin
                        dev_state_ff <= DEV_NORMAL;
                    end
                end
                DEV_SELF_REF: begin
                    // Wake flag arrives independent of the sampled clock enable
                    if (sref_wake_s2_ff || dec.cmd == CMD_SREF_OUT) begin
                        dev_state_ff <= DEV_SREF_EXIT;
                        dev_tmr_ff <= TMR_W'(XSNR_CYC);
                    end
                end
                DEV_SREF_EXIT: begin
                    if (dev_tmr_ff <= TMR_W'(1)) begin
                        dev_state_ff <= DEV_NORMAL;
                    end else begin
                        dev_tmr_ff <= dev_tmr_ff - TMR_W'(1);
                    end
                end
                default: dev_state_ff <= DEV_NORMAL;
            endcase
        end
    end

    // Termination works everywhere except self refresh
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            odt_active_ff <= 1'b0;
        end else begin
            odt_active_ff <= odt && (dev_state_ff != DEV_SELF_REF);
        end
    end

    // Per-bank acceptance check for the current command
    function automatic logic accept(input dcbs_cmd_t c, input dcbs_bank_t st, input logic idle_all);
        case (c)
            CMD_ACT: accept = (st == BK_IDLE);
            CMD_REF, CMD_MODE: accept = idle_all;
            CMD_RD, CMD_WR: accept = (st == BK_ACTIVE) || (st == BK_READ) || (st == BK_WRITE);
            CMD_PRE: accept = (st == BK_ACTIVE) || (st == BK_READ) || (st == BK_WRITE) || (st == BK_IDLE);
            default: accept = 1'b0;
        endcase
    endfunction

    logic tgt_ok;
    logic pre_all_ok;

    assign tgt_ok = accept(dec.cmd, bank_ff[dec.bank[BANK_BITS-1:0]], all_idle);

    // Precharge-all needs every bank in a precharge-capable state
    always_comb begin
        pre_all_ok = 1'b1;
        for (int i = 0; i < NB; i++) begin
            if (!accept(CMD_PRE, bank_ff[i], 1'b0)) begin
                pre_all_ok = 1'b0;
            end
        end
    end

    logic live;
    logic ok;
    assign live = (dev_state_ff == DEV_NORMAL) && xsnr_done;
    assign ok = live && ((dec.cmd == CMD_PRE_ALL) ? pre_all_ok : tgt_ok);

    // Per-bank state and timers
    for (genvar b = 0; b < NB; b++) begin : g_bank
        logic hit;
        assign hit = ok && (dec.bank[BANK_BITS-1:0] == BANK_BITS'(b));
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                bank_ff[b] <= BK_IDLE;
                bank_tmr_ff[b] <= '0;
                bank_ap_ff[b] <= 1'b0;
            end else if (ok && (dec.cmd == CMD_REF || dec.cmd == CMD_MODE)) begin
                bank_ff[b] <= BK_BUSY;
                bank_tmr_ff[b] <= TMR_W'(dec.cmd == CMD_REF ? RFC_CYC : MRD_CYC);
            end else if (ok && dec.cmd == CMD_PRE_ALL) begin
                bank_ff[b] <= BK_PRECHARGING;
                bank_tmr_ff[b] <= TMR_W'(RP_CYC);
            end else if (hit && dec.cmd == CMD_PRE) begin
                bank_ff[b] <= BK_PRECHARGING;
                bank_tmr_ff[b] <= TMR_W'(RP_CYC);
            end else if (hit && dec.cmd == CMD_ACT) begin
                bank_ff[b] <= BK_ACTIVATING;
                bank_tmr_ff[b] <= TMR_W'(RCD_CYC);
            end else if (hit && (dec.cmd == CMD_RD || dec.cmd == CMD_WR)) begin
                bank_ff[b] <= (dec.cmd == CMD_RD) ? BK_READ : BK_WRITE;
                bank_tmr_ff[b] <= TMR_W'(BURST_CYC);
                bank_ap_ff[b] <= dec.auto_pre;
            end else begin
                // Deselect, NOP and rejected commands leave timers running
                case (bank_ff[b])
                    BK_IDLE: bank_tmr_ff[b] <= '0;
                    BK_ACTIVE: bank_tmr_ff[b] <= '0;
                    BK_ACTIVATING, BK_PRECHARGING, BK_BUSY: begin
                        if (bank_tmr_ff[b] <= TMR_W'(1)) begin
                            bank_ff[b] <= (bank_ff[b] == BK_ACTIVATING) ? BK_ACTIVE : BK_IDLE;
                            bank_tmr_ff[b] <= '0;
                        end else begin
                            bank_tmr_ff[b] <= bank_tmr_ff[b] - TMR_W'(1);
                        end
                    end
                    BK_READ, BK_WRITE: begin
                        // Burst runs to completion; auto precharge follows if it was requested
                        if (bank_tmr_ff[b] <= TMR_W'(1)) begin
                            bank_ff[b] <= bank_ap_ff[b] ? BK_PRECHARGING : BK_ACTIVE;
                            bank_tmr_ff[b] <= bank_ap_ff[b] ? TMR_W'(RP_CYC) : '0;
                            bank_ap_ff[b] <= 1'b0;
                        end else begin
                            bank_tmr_ff[b] <= bank_tmr_ff[b] - TMR_W'(1);
                        end
                    end
                    default: bank_ff[b] <= BK_IDLE;
                endcase
            end
        end
    end

    // Registered command reports
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ff <= '{cmd: CMD_NONE, bank: 3'h0, addr: 14'h0000, auto_pre: 1'b0};
            cmd_accepted_ff <= 1'b0;
            cmd_rejected_ff <= 1'b0;
            mode_load_ff <= 1'b0;
            mode_sel_ff <= 3'h0;
            mode_op_ff <= 14'h0000;
            act_ff <= 1'b0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            access_bank_ff <= 3'h0;
            access_addr_ff <= 14'h0000;
            refresh_ff <= 1'b0;
        end else begin
            cmd_ff <= dec;
            cmd_accepted_ff <= ok;
            cmd_rejected_ff <= live && !ok && cke_prev_ff && pin_s2_ff.cke && !pin_s2_ff.cs_n
                && dec.cmd != CMD_NONE;
            mode_load_ff <= ok && dec.cmd == CMD_MODE;
            if (ok && dec.cmd == CMD_MODE) begin
                mode_sel_ff <= dec.bank;
                mode_op_ff <= dec.addr;
            end
            act_ff <= ok && dec.cmd == CMD_ACT;
            rd_ff <= ok && dec.cmd == CMD_RD;
            wr_ff <= ok && dec.cmd == CMD_WR;
            if (ok) begin
                access_bank_ff <= dec.bank;
                access_addr_ff <= dec.addr;
            end
            refresh_ff <= ok && dec.cmd == CMD_REF;
        end
    end

    // Visible bank states; unused banks read as idle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < BANKS_MAX; i++) begin
                bank_state_ff[i] <= BK_IDLE;
            end
        end else begin
            for (int i = 0; i < BANKS_MAX; i++) begin
                bank_state_ff[i] <= (i < NB) ? bank_ff[i % NB] : BK_IDLE;
            end
        end
    end
endmodule // dcbs_decoder

// *** verilog/dcbs_pkg.sv ***
// Package: command codes, bank states and timing constants for the command/bank decoder
package dcbs_pkg;
    localparam int CLK_MHZ = 100;
    // Timing figures in ns, derived cycle counts rounded up
    localparam int T_RP_NS = 15;
    localparam int T_RCD_NS = 15;
    localparam int T_RFC_NS = 105;
    localparam int T_MRD_NS = 20;
    localparam int T_XSNR_NS = 115;
    localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int MRD_CYC = (T_MRD_NS * CLK_MHZ + 999) / 1000;
    localparam int XSNR_CYC = (T_XSNR_NS * CLK_MHZ + 999) / 1000;
    localparam int BURST_LEN = 4;
    localparam int BURST_CYC = BURST_LEN / 2;
    localparam int TMR_W = 8;
    localparam int AUTO_PRE_BIT = 10;
    localparam int BANKS_MAX = 8;

    typedef enum logic [12:0] {
        CMD_NONE = 13'h0001,
        CMD_MODE = 13'h0002,
        CMD_REF = 13'h0004,
        CMD_SREF_IN = 13'h0008,
        CMD_SREF_OUT = 13'h0010,
        CMD_PRE = 13'h0020,
        CMD_PRE_ALL = 13'h0040,
        CMD_ACT = 13'h0080,
        CMD_WR = 13'h0100,
        CMD_RD = 13'h0200,
        CMD_PD_IN = 13'h0400,
        CMD_PD_OUT = 13'h0800,
        CMD_ILLEGAL = 13'h1000
    } dcbs_cmd_t;

    typedef enum logic [6:0] {
        BK_IDLE = 7'h01,
        BK_ACTIVATING = 7'h02,
        BK_ACTIVE = 7'h04,
        BK_READ = 7'h08,
        BK_WRITE = 7'h10,
        BK_PRECHARGING = 7'h20,
        BK_BUSY = 7'h40
    } dcbs_bank_t;

    typedef enum logic [3:0] {
        DEV_NORMAL = 4'h1,
        DEV_POWER_DOWN = 4'h2,
        DEV_SELF_REF = 4'h4,
        DEV_SREF_EXIT = 4'h8
    } dcbs_dev_t;

    // Command pins as sampled at the clock edge
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank;
        logic [13:0] addr;
    } dcbs_pins_t;

    // Decoded command as handed to the core
    typedef struct packed {
        dcbs_cmd_t cmd;
        logic [2:0] bank;
        logic [13:0] addr;
        logic auto_pre;
    } dcbs_dec_t;
endpackage : dcbs_pkg

// *** verif/dcbs_decoder_sva.sv ***
// Checker: decoder outputs against the sampled command pins
module dcbs_decoder_sva (
    input wire logic mclk,
    input wire logic reset_n,
    input wire dcbs_pkg::dcbs_pins_t pins,
    input wire logic odt,
    input wire logic odt_active_ff,
    input wire dcbs_pkg::dcbs_dec_t cmd_ff,
    input wire logic cmd_accepted_ff,
    input wire logic cmd_rejected_ff,
    input wire logic mode_load_ff,
    input wire logic [2:0] mode_sel_ff,
    input wire logic [13:0] mode_op_ff,
    input wire logic act_ff,
    input wire logic rd_ff,
    input wire logic wr_ff,
    input wire logic [2:0] access_bank_ff,
    input wire logic [13:0] access_addr_ff,
    input wire logic refresh_ff,
    input wire dcbs_pkg::dcbs_dev_t dev_state_ff,
    input wire logic [6:0] bank_state_ff [8]
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcbs_pkg::*;
    dcbs_pins_t dly_ff [4];
    logic [3:0] c4;
    logic ck2;
    logic quiet;
    // Pins lined up with the two sync stages and the report register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) dly_ff[i] <= '1;
        end else begin
            dly_ff[0] <= pins;
            for (int i = 1; i < 4; i++) dly_ff[i] <= dly_ff[i - 1];
        end
    end
    // Strobe code and clock enable of the command behind each pulse
    assign c4 = {dly_ff[2].cs_n, dly_ff[2].ras_n, dly_ff[2].cas_n, dly_ff[2].we_n};
    assign ck2 = dly_ff[2].cke && dly_ff[3].cke;
    assign quiet = !(act_ff || rd_ff || wr_ff || refresh_ff || mode_load_ff);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_act; act_ff |-> c4 == 4'h3 && ck2; endproperty
    property p_rd; rd_ff |-> c4 == 4'h5 && ck2; endproperty
    property p_wr; wr_ff |-> c4 == 4'h4 && ck2; endproperty
    property p_ref; refresh_ff |-> c4 == 4'h1 && ck2; endproperty
    property p_mode;
        mode_load_ff |-> c4 == 4'h0 && mode_sel_ff == dly_ff[2].bank && mode_op_ff == dly_ff[2].addr;
    endproperty
    property p_col;
        (rd_ff || wr_ff) |-> access_bank_ff == dly_ff[2].bank && access_addr_ff == dly_ff[2].addr;
    endproperty
    property p_open;
        act_ff |-> ##1 bank_state_ff[access_bank_ff] == BK_ACTIVATING ##2 bank_state_ff[access_bank_ff] == BK_ACTIVE;
    endproperty
    property p_nop; (dly_ff[2].cs_n || c4 == 4'h7) |-> quiet; endproperty
    property p_rej;
        cmd_rejected_ff |-> quiet && !cmd_accepted_ff && ck2 && !dly_ff[2].cs_n && c4 != 4'h7;
    endproperty
    property p_odt; (dev_state_ff == DEV_SELF_REF) [*3] |-> !odt_active_ff; endproperty
    property p_rfc;
        refresh_ff |-> ##1 (bank_state_ff[5] == BK_BUSY) [*8] ##1 (bank_state_ff[5] == BK_BUSY) [*3]
            ##1 bank_state_ff[5] == BK_IDLE;
    endproperty
    a_act: assert property (p_act) else $error("activate pulse without activate levels");
    a_rd: assert property (p_rd) else $error("read pulse without read levels");
    a_wr: assert property (p_wr) else $error("write pulse without write levels");
    a_ref: assert property (p_ref) else $error("refresh pulse without refresh levels");
    a_mode: assert property (p_mode) else $error("mode select or opcode wrong");
    a_col: assert property (p_col) else $error("access bank or column wrong");
    a_open: assert property (p_open) else $error("bank did not open in time");
    a_nop: assert property (p_nop) else $error("idle command started work");
    a_rej: assert property (p_rej) else $error("rejected command acted");
    a_odt: assert property (p_odt) else $error("termination live in self refresh");
    a_rfc: assert property (p_rfc) else $error("refresh busy time wrong");
    c_act: cover property (act_ff);
    c_rej: cover property (cmd_rejected_ff);
    c_sref: cover property (dev_state_ff == DEV_SELF_REF);
    c_mode: cover property (mode_load_ff);
endmodule // dcbs_decoder_sva

bind dcbs_decoder dcbs_decoder_sva u_sva (.mclk(mclk), .reset_n(reset_n), .pins(pins), .odt(odt),
    .odt_active_ff(odt_active_ff), .cmd_ff(cmd_ff), .cmd_accepted_ff(cmd_accepted_ff),
    .cmd_rejected_ff(cmd_rejected_ff), .mode_load_ff(mode_load_ff), .mode_sel_ff(mode_sel_ff),
    .mode_op_ff(mode_op_ff), .act_ff(act_ff), .rd_ff(rd_ff), .wr_ff(wr_ff), .access_bank_ff(access_bank_ff),
    .access_addr_ff(access_addr_ff), .refresh_ff(refresh_ff), .dev_state_ff(dev_state_ff),
    .bank_state_ff(bank_state_ff));

// *** verif/dcbs_ctrl_model.sv ***
// Controller model: command pins, deselect with moving lines between commands
module dcbs_ctrl_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire dcbs_pkg::dcbs_pins_t req,
    input wire logic req_valid,
    input wire logic cke_lvl,
    output dcbs_pkg::dcbs_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcbs_pkg::*;
    logic [19:0] junk_ff;
    // Don't-care lines change every cycle so stale levels are never relied on
    always_ff @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            junk_ff <= 20'h1;
        end else begin
            junk_ff <= {junk_ff[18:0], junk_ff[19] ^ junk_ff[16]};
        end
    end
    // Levels held a full cycle around the rising edge; only legal commands asked for
    assign pins = req_valid ? req : {cke_lvl, 1'b1, junk_ff};
endmodule // dcbs_ctrl_model

// *** verif/ddr2_command_bank_state_decoder_bench.sv ***
// Bench: random and corner command traffic into the decoder
module ddr2_command_bank_state_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcbs_pkg::*;
    logic mclk, reset_n, odt, req_valid, cke_lvl;
    logic odt_active_ff, cmd_accepted_ff, cmd_rejected_ff, mode_load_ff, act_ff, rd_ff, wr_ff, refresh_ff;
    dcbs_pins_t req, pins;
    dcbs_dec_t cmd_ff, got_dec;
    dcbs_dev_t dev_state_ff;
    logic [2:0] mode_sel_ff, access_bank_ff;
    logic [13:0] mode_op_ff, access_addr_ff;
    logic [6:0] bank_state_ff [8];
    logic [31:0] seed;
    logic [1:0] resp;
    logic [4:0] hit;
    int n_errors, samples_checked;

    dcbs_ctrl_model u_ctrl (.mclk(mclk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
        .cke_lvl(cke_lvl), .pins(pins));
    dcbs_decoder u_dut (.mclk(mclk), .reset_n(reset_n), .pins(pins), .odt(odt), .odt_active_ff(odt_active_ff),
        .cmd_ff(cmd_ff), .cmd_accepted_ff(cmd_accepted_ff), .cmd_rejected_ff(cmd_rejected_ff),
        .mode_load_ff(mode_load_ff), .mode_sel_ff(mode_sel_ff), .mode_op_ff(mode_op_ff), .act_ff(act_ff),
        .rd_ff(rd_ff), .wr_ff(wr_ff), .access_bank_ff(access_bank_ff), .access_addr_ff(access_addr_ff),
        .refresh_ff(refresh_ff), .dev_state_ff(dev_state_ff), .bank_state_ff(bank_state_ff));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Pins from a {cs,ras,cas,we} code, clock enable high
    function automatic dcbs_pins_t mk(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        return {1'b1, c, b, a};
    endfunction
    // Expected answer by bank state: 1 accept, 2 reject
    function automatic logic [1:0] exp_resp(input logic [6:0] st, input logic [3:0] c);
        if (st == BK_IDLE) return (c <= 4'h3) ? 2'h1 : 2'h2;
        return (c == 4'h5 || c == 4'h4 || c == 4'h2) ? 2'h1 : 2'h2;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One command, then deselect; answer caught within a bounded window
    task automatic do_cmd(input dcbs_pins_t p);
        @(negedge mclk);
        req <= p;
        req_valid <= 1'b1;
        @(negedge mclk);
        req_valid <= 1'b0;
        resp = 2'h0;
        for (int i = 0; i < 8 && resp == 2'h0; i++) begin
            @(negedge mclk);
            resp = {cmd_rejected_ff, cmd_accepted_ff};
            hit = {act_ff, rd_ff, wr_ff, refresh_ff, mode_load_ff};
            got_dec = cmd_ff;
        end
    endtask
    // Bounded wait for a bank state (w<8) or device state (w=8)
    task automatic wait_for(input int w, input logic [6:0] exp);
        logic [6:0] got;
        for (int i = 0; i < 60; i++) begin
            @(negedge mclk);
            got = (w < 8) ? bank_state_ff[w] : 7'(dev_state_ff);
            if (got === exp) break;
        end
        chk(32'(got), 32'(exp));
    endtask
    task automatic do_reset();
        @(negedge mclk);
        reset_n <= 1'b0;
        repeat (3) @(negedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(negedge mclk);
    endtask
    task automatic end_of_test();
        $display("samples_checked=%0d n_errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #500us;
        n_errors++;
        end_of_test();
    end

    initial begin
        logic [2:0] b;
        logic [13:0] a;
        logic [3:0] c;
        seed = 32'hf6a;
        reset_n = 1'b0;
        odt = 1'b0;
        req_valid = 1'b0;
        cke_lvl = 1'b1;
        req = '1;
        repeat (3) @(posedge mclk);
        @(negedge mclk) reset_n <= 1'b1;
        wait_for(3, BK_IDLE);
        wait_for(8, 7'(DEV_NORMAL));
        // Random rounds: open, refuse reopen, access, close
        for (int n = 0; n < 12; n++) begin
            b = 3'(rnd());
            a = 14'(rnd());
            do_cmd(mk(4'h3, b, a));
            chk({resp, hit, access_addr_ff}, {exp_resp(BK_IDLE, 4'h3), 5'h10, a});
            wait_for(b, BK_ACTIVE);
            do_cmd(mk(4'h3, b, a));
            chk(32'(resp), 32'(exp_resp(BK_ACTIVE, 4'h3)));
            c = rnd() & 1 ? 4'h5 : 4'h4;
            a = 14'(rnd());
            do_cmd(mk(c, b, a));
            chk({resp, hit}, {exp_resp(BK_ACTIVE, c), c == 4'h5 ? 5'h08 : 5'h04});
            chk({access_bank_ff, access_addr_ff}, {b, a});
            chk({got_dec.cmd, got_dec.auto_pre}, {((c == 4'h5) ? CMD_RD : CMD_WR), a[10]});
            if (!a[10]) begin
                do_cmd(mk(4'h2, b, a));
                chk(32'(resp), 32'(exp_resp(BK_ACTIVE, 4'h2)));
            end
            wait_for(b, BK_IDLE);
        end
        // Single bank close leaves the other open; all-bank close shuts it
        do_cmd(mk(4'h3, 3'h1, 14'h0));
        do_cmd(mk(4'h3, 3'h6, 14'h0));
        wait_for(6, BK_ACTIVE);
        do_cmd(mk(4'h2, 3'h1, 14'h3bff));
        wait_for(1, BK_IDLE);
        wait_for(6, BK_ACTIVE);
        do_cmd(mk(4'h2, 3'h1, 14'h400));
        wait_for(6, BK_IDLE);
        // Refresh, then an activate while the device is still busy
        do_cmd(mk(4'h1, 3'h0, 14'h0));
        chk({resp, hit}, {2'h1, 5'h02});
        do_cmd(mk(4'h3, 3'h2, 14'h0));
        chk(32'(resp), 32'h2);
        wait_for(2, BK_IDLE);
        b = 3'(rnd());
        a = 14'(rnd());
        do_cmd(mk(4'h0, b, a));
        chk({hit, mode_sel_ff, mode_op_ff}, {5'h01, b, a});
        wait_for(7, BK_IDLE);
        // No-operation and deselect start nothing
        do_cmd(mk(4'h7, 3'h0, 14'h0));
        chk(32'(hit), 32'h0);
        do_cmd({2'h3, 20'(rnd())});
        chk(32'(hit), 32'h0);
        // Short power-down: entry with clock enable low, exit with it high
        @(negedge mclk) cke_lvl <= 1'b0;
        wait_for(8, 7'(DEV_POWER_DOWN));
        @(negedge mclk) cke_lvl <= 1'b1;
        wait_for(8, 7'(DEV_NORMAL));
        // Mid-run reset, then self refresh with termination requested
        do_reset();
        odt <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(32'(odt_active_ff), 32'h1);
        req <= {1'b0, 4'h1, 17'(rnd())};
        req_valid <= 1'b1;
        cke_lvl <= 1'b0;
        @(negedge mclk) req_valid <= 1'b0;
        wait_for(8, 7'(DEV_SELF_REF));
        repeat (4) @(negedge mclk);
        chk(32'(odt_active_ff), 32'h0);
        cke_lvl <= 1'b1;
        wait_for(8, 7'(DEV_NORMAL));
        do_cmd(mk(4'h3, 3'h4, 14'h0));
        chk(32'(resp), 32'h1);
        end_of_test();
    end
endmodule // ddr2_command_bank_state_decoder_bench
